/* hdl/asc_pkg.sv */
// shared constants of the adc sequence controller
package asc_pkg;
	localparam int          ASC_AW        = 8;
	localparam int          ASC_SLOTS     = 16;
	localparam logic [7:0]  ASC_OFS_CTL   = 8'h00;
	localparam logic [7:0]  ASC_OFS_START = 8'h04;
	localparam logic [7:0]  ASC_OFS_STAT  = 8'h08;
	localparam logic [7:0]  ASC_OFS_FLAGS = 8'h0C;
	localparam logic [7:0]  ASC_OFS_OPT   = 8'h10;
	localparam logic [7:0]  ASC_OFS_IST   = 8'h14;
	localparam logic [7:0]  ASC_OFS_IMASK = 8'h18;
	localparam logic [7:0]  ASC_OFS_RES   = 8'h40;
	localparam int          ASC_CTL_LEN   = 3;
	localparam int          ASC_CTL_FIFO  = 2;
	localparam int          ASC_CTL_HALT  = 0;
	localparam logic [3:0]  ASC_LEN_RST   = 4'h4;
	localparam int          ASC_ST_SCAN   = 0;
	localparam int          ASC_ST_EXTERNAL_TRIGGER_MODE  = 1;
	localparam int          ASC_OPT_FAST  = 0;
	localparam int          ASC_IRQ_SEQ   = 0;
	localparam int          ASC_IRQ_CONV  = 1;
	localparam logic [4:0]  ASC_LEN_MAX   = 5'h10;
	localparam logic [1:0]  ASC_RESP_OK   = 2'h0;
	localparam logic [1:0]  ASC_RESP_ERR  = 2'h2;
	typedef enum logic [1:0] {
		ASC_HALT_RUN    = 2'b00,
		ASC_HALT_RSVD   = 2'b01,
		ASC_HALT_FINISH = 2'b10,
		ASC_HALT_NOW    = 2'b11
	} asc_halt_e;
	typedef enum logic [1:0] {
		ASC_IDLE  = 2'b00,
		ASC_ARMED = 2'b01,
		ASC_RUN   = 2'b10
	} asc_phase_e;
	function automatic logic [4:0] asc_seq_len(input logic [3:0] l);
		return (l == 4'h0) ? ASC_LEN_MAX : {1'b0, l};
	endfunction
endpackage

/* hdl/asc_bus_if.sv */
// register access carrier between bus slave and core
`timescale 1ns/10ps
`default_nettype none
interface asc_bus_if;
	logic                      wr_en;
	logic [asc_pkg::ASC_AW-1:0] wr_addr;
	logic [31:0]               wr_data;
	logic [3:0]                wr_strb;
	logic                      wr_hit;
	logic                      rd_en;
	logic [asc_pkg::ASC_AW-1:0] rd_addr;
	logic [31:0]               rd_data;
	logic                      rd_hit;
	modport slv (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		input wr_hit, rd_data, rd_hit);
	modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		output wr_hit, rd_data, rd_hit);
endinterface
`default_nettype wire

/* hdl/asc_axil.sv */
// axi4-lite slave front end
`timescale 1ns/10ps
`default_nettype none
module asc_axil import asc_pkg::*; (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	input  wire logic [ASC_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ASC_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	asc_bus_if.slv                 bus
);
	typedef struct packed {
		logic              aw_ok;
		logic [ASC_AW-1:0] awaddr;
		logic              w_ok;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} asc_axil_s;
	asc_axil_s r;
	asc_axil_s next_r;
	// ****************************************
	// handshakes
	// ****************************************
	assign s_axi_awready = ce & ~r.aw_ok & ~r.bvalid;
	assign s_axi_wready  = ce & ~r.w_ok & ~r.bvalid;
	assign s_axi_arready = ce & ~r.rvalid;
	assign s_axi_bvalid  = r.bvalid;
	assign s_axi_bresp   = r.bresp;
	assign s_axi_rvalid  = r.rvalid;
	assign s_axi_rdata   = r.rdata;
	assign s_axi_rresp   = r.rresp;
	assign bus.wr_en     = ce & r.aw_ok & r.w_ok & ~r.bvalid;
	assign bus.wr_addr   = {r.awaddr[ASC_AW-1:2], 2'b00};
	assign bus.wr_data   = r.wdata;
	assign bus.wr_strb   = r.wstrb;
	assign bus.rd_en     = s_axi_arvalid & s_axi_arready;
	assign bus.rd_addr   = {s_axi_araddr[ASC_AW-1:2], 2'b00};
	always_comb begin
		next_r = r;
		if (s_axi_awvalid & s_axi_awready) begin
			next_r.aw_ok  = 1'b1;
			next_r.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid & s_axi_wready) begin
			next_r.w_ok  = 1'b1;
			next_r.wdata = s_axi_wdata;
			next_r.wstrb = s_axi_wstrb;
		end
		if (bus.wr_en) begin
			next_r.aw_ok  = 1'b0;
			next_r.w_ok   = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp  = bus.wr_hit ? ASC_RESP_OK : ASC_RESP_ERR;
		end else if (r.bvalid & s_axi_bready) begin
			next_r.bvalid = 1'b0;
		end
		if (bus.rd_en) begin
			next_r.rvalid = 1'b1;
			next_r.rdata  = bus.rd_hit ? bus.rd_data : 32'h0000_0000;
			next_r.rresp  = bus.rd_hit ? ASC_RESP_OK : ASC_RESP_ERR;
		end else if (r.rvalid & s_axi_rready) begin
			next_r.rvalid = 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
		end else if (ce) begin
			r <= next_r;
		end
	end
endmodule
`default_nettype wire

/* hdl/asc_top.sv */
// adc conversion sequence controller with register file
// ****************************************
// ****************************************
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module asc_top import asc_pkg::*; #(
	parameter int RES_W = 10
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	input  wire logic [ASC_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ASC_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              ext_trigger,
	input  wire logic              debug_freeze,
	output logic                   conv_start,
	output logic                   conv_abort,
	output logic                   conv_hold,
	output logic [3:0]             conv_slot,
	input  wire logic              conv_done,
	input  wire logic [RES_W-1:0]  conv_data,
	output logic                   irq
);
	typedef struct packed {
		logic [3:0]                      len;
		logic                            fifo;
		asc_halt_e                       halt;
		logic                            fast;
		logic                            scan;
		logic                            external_trigger_mode;
		asc_phase_e                      ph;
		logic                            in_conv;
		logic                            start_p;
		logic                            abort_p;
		logic [3:0]                      slot;
		logic [4:0]                      cnt;
		logic [ASC_SLOTS-1:0]            ccf;
		logic [ASC_SLOTS-1:0]            armed;
		logic [ASC_SLOTS-1:0][RES_W-1:0] res;
		logic [1:0]                      ist;
		logic [1:0]                      imask;
		logic                            t1;
		logic                            t2;
		logic                            t3;
		logic                            f1;
		logic                            f2;
	} asc_core_s;
	asc_core_s    r;
	asc_core_s    next_r;
	logic         done;
	logic         trig_edge;
	logic         freeze_stop;
	logic         last_conv;
	logic         rd_res;
	logic         wr_res;
	logic         wr_ctl;
	logic         wr_start;
	logic [3:0]   rd_idx;
	logic [3:0]   wr_idx;
	asc_bus_if    bus ();
	// ****************************************
	// register decode helpers
	// ****************************************
	function automatic logic asc_is_res(input logic [ASC_AW-1:0] a);
		return a[ASC_AW-1:6] == ASC_OFS_RES[ASC_AW-1:6];
	endfunction
	function automatic logic asc_known(input logic [ASC_AW-1:0] a);
		return asc_is_res(a) || a == ASC_OFS_CTL || a == ASC_OFS_START ||
			a == ASC_OFS_STAT || a == ASC_OFS_FLAGS || a == ASC_OFS_OPT ||
			a == ASC_OFS_IST || a == ASC_OFS_IMASK;
	endfunction
	// ****************************************
	// bus slave
	// ****************************************
	asc_axil u_axil (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.ce            (ce),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.bus           (bus.slv)
	);
	// ****************************************
	// combinational decode
	// ****************************************
	assign done        = conv_done & r.in_conv;
	assign trig_edge   = r.t2 & ~r.t3;
	assign freeze_stop = r.f2 & (r.halt == ASC_HALT_FINISH || r.halt == ASC_HALT_NOW);
	assign last_conv   = (r.cnt + 5'h01) == asc_seq_len(r.len);
	assign rd_res      = bus.rd_en & asc_is_res(bus.rd_addr);
	assign wr_res      = bus.wr_en & asc_is_res(bus.wr_addr);
	assign wr_ctl      = bus.wr_en & (bus.wr_addr == ASC_OFS_CTL);
	assign wr_start    = bus.wr_en & (bus.wr_addr == ASC_OFS_START);
	assign rd_idx      = bus.rd_addr[5:2];
	assign wr_idx      = bus.wr_addr[5:2];
	assign bus.wr_hit  = asc_known(bus.wr_addr);
	assign bus.rd_hit  = asc_known(bus.rd_addr);
	// immediate halt holds the converter mid conversion
	assign conv_hold   = r.f2 & (r.halt == ASC_HALT_NOW) & r.in_conv;
	assign conv_start  = r.start_p;
	assign conv_abort  = r.abort_p;
	assign conv_slot   = r.slot;
	assign irq         = |(r.ist & r.imask);
	// ****************************************
	// read mux
	// ****************************************
	always_comb begin
		bus.rd_data = 32'h0000_0000;
		if (asc_is_res(bus.rd_addr)) begin
			bus.rd_data[RES_W-1:0] = r.res[rd_idx];
		end else begin
			unique case (bus.rd_addr)
				ASC_OFS_CTL: begin
					bus.rd_data[6:0] = {r.len, r.fifo, r.halt};
				end
				ASC_OFS_START: begin
					bus.rd_data[1:0] = {r.external_trigger_mode, r.scan};
				end
				ASC_OFS_STAT: begin
					bus.rd_data[5:0] = {freeze_stop & (r.ph == ASC_RUN),
						r.ph != ASC_IDLE, r.slot};
				end
				ASC_OFS_FLAGS: begin
					bus.rd_data[ASC_SLOTS-1:0] = r.ccf;
				end
				ASC_OFS_OPT: begin
					bus.rd_data[ASC_OPT_FAST] = r.fast;
				end
				ASC_OFS_IST: begin
					bus.rd_data[1:0] = r.ist;
				end
				ASC_OFS_IMASK: begin
					bus.rd_data[1:0] = r.imask;
				end
				default: begin
					bus.rd_data = 32'h0000_0000;
				end
			endcase
		end
	end
	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_r         = r;
		next_r.start_p = 1'b0;
		next_r.abort_p = 1'b0;
		next_r.t1      = ext_trigger;
		next_r.t2      = r.t1;
		next_r.t3      = r.t2;
		next_r.f1      = debug_freeze;
		next_r.f2      = r.f1;
		// result lands in the current slot
		if (done) begin
			next_r.in_conv      = 1'b0;
			next_r.res[r.slot]  = conv_data;
			// four bit counter wraps to slot zero
			next_r.slot         = r.slot + 4'h1;
			next_r.cnt          = r.cnt + 5'h01;
			if (last_conv) begin
				next_r.cnt = 5'h00;
				if (!r.fifo) begin
					next_r.slot = 4'h0;
				end
				if (!r.scan) begin
					next_r.ph = r.external_trigger_mode ? ASC_ARMED : ASC_IDLE;
				end
			end
		end
		unique case (r.ph)
			ASC_IDLE: begin
				next_r.ph = next_r.ph;
			end
			ASC_ARMED: begin
				if (trig_edge) begin
					next_r.ph = ASC_RUN;
				end
			end
			ASC_RUN: begin
				if (!r.in_conv && !freeze_stop) begin
					next_r.in_conv = 1'b1;
					next_r.start_p = 1'b1;
				end
			end
			default: begin
				next_r.ph = ASC_IDLE;
			end
		endcase
		if (rd_res && (r.fast || r.armed[rd_idx])) begin
			next_r.ccf[rd_idx]   = 1'b0;
			next_r.armed[rd_idx] = 1'b0;
		end
		if (wr_res && r.fast) begin
			next_r.ccf[wr_idx] = 1'b0;
		end
		if (bus.rd_en && bus.rd_addr == ASC_OFS_FLAGS) begin
			next_r.armed = r.ccf;
		end
		if (bus.wr_en && bus.wr_strb[0]) begin
			unique case (bus.wr_addr)
				ASC_OFS_CTL: begin
					next_r.len  = bus.wr_data[ASC_CTL_LEN+:4];
					next_r.fifo = bus.wr_data[ASC_CTL_FIFO];
					next_r.halt = asc_halt_e'(bus.wr_data[ASC_CTL_HALT+:2]);
				end
				ASC_OFS_START: begin
					next_r.scan  = bus.wr_data[ASC_ST_SCAN];
					next_r.external_trigger_mode = bus.wr_data[ASC_ST_EXTERNAL_TRIGGER_MODE];
				end
				ASC_OFS_OPT: begin
					next_r.fast = bus.wr_data[ASC_OPT_FAST];
				end
				ASC_OFS_IST: begin
					next_r.ist = r.ist & ~bus.wr_data[1:0];
				end
				ASC_OFS_IMASK: begin
					next_r.imask = bus.wr_data[1:0];
				end
				default: begin
					next_r.ist = next_r.ist;
				end
			endcase
		end
		if (wr_ctl || wr_start ||
			(bus.wr_en && bus.wr_addr == ASC_OFS_OPT)) begin
			next_r.abort_p = r.in_conv;
			next_r.ph      = ASC_IDLE;
			next_r.in_conv = 1'b0;
			next_r.start_p = 1'b0;
			next_r.slot    = 4'h0;
			next_r.cnt     = 5'h00;
		end
		if (wr_start) begin
			next_r.ph = next_r.external_trigger_mode ? ASC_ARMED : ASC_RUN;
		end
		if (done) begin
			next_r.ccf[r.slot]   = 1'b1;
			next_r.armed[r.slot] = 1'b0;
			next_r.ist[ASC_IRQ_CONV] = 1'b1;
			if (last_conv) begin
				next_r.ist[ASC_IRQ_SEQ] = 1'b1;
			end
		end
	end
	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
			r.len <= ASC_LEN_RST;
		end else if (ce) begin
			r <= next_r;
		end
	end
	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_accept;
		ce && done && !bus.wr_en;
	endsequence
	sequence s_seq_end;
		s_accept ##0 last_conv;
	endsequence
	a_ctl_abort: assert property (ce && wr_ctl |=> r.ph == ASC_IDLE && !r.in_conv)
		else $error("control write did not abort");
	a_len_count: assert property (s_seq_end ##0 (!r.scan && !r.external_trigger_mode) |=> r.ph == ASC_IDLE)
		else $error("sequence length not honoured");
	a_reset_len: assert property ($rose(aresetn) |-> r.len == ASC_LEN_RST)
		else $error("reset length is not four");
	a_fixed_slot: assert property (s_accept ##0 !r.fifo |-> r.slot == r.cnt[3:0])
		else $error("fixed mode slot mismatch");
	a_fifo_keep: assert property (s_seq_end ##0 r.fifo |=> r.slot == $past(r.slot) + 4'h1)
		else $error("fifo counter reset at sequence end");
	a_fifo_wrap: assert property (s_accept ##0 (r.slot == 4'hF) |=> r.slot == 4'h0)
		else $error("slot counter did not wrap");
	a_stat_slot: assert property (bus.rd_en && bus.rd_addr == ASC_OFS_STAT
		|=> s_axi_rvalid && s_axi_rdata[3:0] == $past(conv_slot))
		else $error("status slot mismatch");
	a_start_clear: assert property (ce && wr_start |=> r.slot == 4'h0 && r.cnt == 5'h00)
		else $error("start write left slot counter");
	a_flag_set: assert property (s_accept |=> r.ccf[$past(r.slot)])
		else $error("complete flag not set");
	a_hold_now: assert property (ce && r.f2 && r.halt == ASC_HALT_NOW && r.in_conv
		|-> conv_hold ##1 !conv_start)
		else $error("immediate halt not held");
	a_fast_clear: assert property (ce && rd_res && r.fast && !done |=> !r.ccf[$past(rd_idx)])
		else $error("fast clear missed");
	a_resume: assert property (ce && r.ph == ASC_RUN && !r.in_conv && !freeze_stop
		&& !bus.wr_en |=> conv_start && r.in_conv)
		else $error("sequence did not resume");
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the adc sequence controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) \
	begin \
		compares++; \
		if ((g) !== (e)) begin \
			bad_count++; \
			$display("[ERR] %0t mismatch got %0h exp %0h", $time, (g), (e)); \
		end \
	end
module tb_top import asc_pkg::*;;
	logic              aclk, aresetn, ce;
	logic [ASC_AW-1:0] awaddr, araddr;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	logic [31:0]       wdata, rdata, rd, m;
	logic [3:0]        wstrb, e;
	logic [1:0]        bresp, rresp, rsp;
	logic              ext_trigger, debug_freeze, conv_start, conv_abort, conv_hold;
	logic [3:0]        conv_slot;
	logic              conv_done, irq, pend;
	logic [9:0]        conv_data;
	logic [3:0]        slots[$];
	logic [3:0]        codes[2] = '{4'h3, 4'h0};
	int                bad_count, compares, n_abort, len, last, i, j, base;

	asc_top #(.RES_W(10)) uut (
		.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_trigger(ext_trigger),
		.debug_freeze(debug_freeze), .conv_start(conv_start), .conv_abort(conv_abort),
		.conv_hold(conv_hold), .conv_slot(conv_slot), .conv_done(conv_done),
		.conv_data(conv_data), .irq(irq)
	);

	initial aclk = 1'b0;
	always #5 aclk = ~aclk;

	// ****************************************
	// converter responder and start monitor
	// ****************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			conv_done <= 1'b0;
			pend      <= 1'b0;
		end else begin
			conv_done <= (pend || conv_start === 1'b1) && conv_hold !== 1'b1;
			pend      <= (pend || conv_start === 1'b1) && conv_hold === 1'b1;
		end
		conv_data <= 10'h100 + {6'h0, conv_slot};
		if (conv_start === 1'b1) slots.push_back(conv_slot);
		if (conv_abort === 1'b1) n_abort++;
	end

	// ****************************************
	// bus tasks
	// ****************************************
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic fail_timeout();
		bad_count++;
		$display("[ERR] %0t wait bound used up", $time);
		report_and_stop();
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int   k;
		logic aw, w, b;
		@(posedge aclk);
		aw = 1'b1;
		w = 1'b1;
		b = 1'b1;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 60 && b; k++) begin
			@(negedge aclk);
			if (awvalid && awready) aw = 1'b0;
			if (wvalid && wready) w = 1'b0;
			if (bvalid && bready) b = 1'b0;
			r = bresp;
			@(posedge aclk);
			if (!aw) awvalid <= 1'b0;
			if (!w) wvalid <= 1'b0;
			if (!b) bready <= 1'b0;
		end
		if (b) fail_timeout();
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int   k;
		logic ar, rr;
		@(posedge aclk);
		ar = 1'b1;
		rr = 1'b1;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 60 && rr; k++) begin
			@(negedge aclk);
			if (arvalid && arready) ar = 1'b0;
			if (rvalid && rready) rr = 1'b0;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (!ar) arvalid <= 1'b0;
			if (!rr) rready <= 1'b0;
		end
		if (rr) fail_timeout();
		@(posedge aclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi_wr(a, d, rsp);
		`CHK(rsp, ASC_RESP_OK)
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
		axi_rd(a, rd, rsp);
		`CHK(rd, x)
	endtask

	task automatic wait_q(input int c);
		int k;
		for (k = 0; k < 600 && slots.size() - base < c; k++) @(negedge aclk);
		if (slots.size() - base < c) fail_timeout();
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{aresetn, awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
		{wdata, wstrb, ext_trigger, debug_freeze} = '0;
		ce = 1'b1;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdchk(ASC_OFS_CTL, 32'h0000_0020);
		rdchk(ASC_OFS_STAT, 32'h0000_0000);
		axi_rd(8'h30, rd, rsp);
		`CHK({rsp, rd}, {ASC_RESP_ERR, 32'h0000_0000})
		axi_wr(8'h30, 32'h0000_0001, rsp);
		`CHK(rsp, ASC_RESP_ERR)
		$display("test reset and map done");
		wr(ASC_OFS_IMASK, 32'h0000_0001);
		for (i = 0; i < 2; i++) begin
			len = (codes[i] == 4'h0) ? 16 : int'(codes[i]);
			last = len - 1;
			m = (32'h0000_0001 << len) - 32'h0000_0001;
			wr(ASC_OFS_CTL, {25'h0, codes[i], 3'b000});
			base = slots.size();
			wr(ASC_OFS_START, 32'h0000_0000);
			wait_q(len);
			repeat (20) @(negedge aclk);
			`CHK(slots.size() - base, len)
			for (j = 0; j < len; j++) `CHK(slots[base + j], j[3:0])
			rdchk(ASC_OFS_FLAGS, m);
			rdchk(ASC_OFS_RES + {last[5:0], 2'b00}, {22'h0, 10'h100 + last[9:0]});
			rdchk(ASC_OFS_FLAGS, m >> 1);
		end
		@(negedge aclk);
		`CHK(irq, 1'b1)
		wr(ASC_OFS_IST, 32'h0000_0001);
		@(negedge aclk);
		`CHK(irq, 1'b0)
		rdchk(ASC_OFS_IST, 32'h0000_0002);
		wr(ASC_OFS_IMASK, 32'h0000_0002);
		@(negedge aclk);
		`CHK(irq, 1'b1)
		wr(ASC_OFS_IST, 32'h0000_0002);
		@(negedge aclk);
		`CHK(irq, 1'b0)
		$display("test fixed mode, lengths and interrupt done");
		wr(ASC_OFS_OPT, 32'h0000_0001);
		rdchk(ASC_OFS_RES, 32'h0000_0100);
		rdchk(ASC_OFS_FLAGS, 32'h0000_7FFE);
		axi_wr(ASC_OFS_RES + 8'h04, 32'h0000_0000, rsp);
		rdchk(ASC_OFS_FLAGS, 32'h0000_7FFC);
		wr(ASC_OFS_OPT, 32'h0000_0000);
		$display("test fast clear done");
		wr(ASC_OFS_CTL, 32'h0000_0014);
		base = slots.size();
		wr(ASC_OFS_START, 32'h0000_0001);
		wait_q(18);
		for (j = 0; j < 18; j++) `CHK(slots[base + j], j[3:0])
		last = n_abort;
		wr(ASC_OFS_CTL, 32'h0000_0014);
		base = slots.size();
		repeat (20) @(negedge aclk);
		`CHK(slots.size() - base, 0)
		`CHK(n_abort > last, 1'b1)
		rdchk(ASC_OFS_STAT, 32'h0000_0000);
		$display("test fifo wrap and abort done");
		for (i = 0; i < 4; i++) begin
			wr(ASC_OFS_CTL, {30'h0, i[1:0]} | 32'h0000_0020);
			base = slots.size();
			wr(ASC_OFS_START, 32'h0000_0001);
			wait_q(3);
			repeat (3) @(posedge aclk);
			debug_freeze <= 1'b1;
			repeat (8) @(posedge aclk);
			base = slots.size();
			repeat (30) @(negedge aclk);
			`CHK(conv_hold, i == 3)
			`CHK(slots.size() == base, i >= 2)
			axi_rd(ASC_OFS_STAT, rd, rsp);
			e = rd[3:0] + {3'b000, pend};
			debug_freeze <= 1'b0;
			base = slots.size();
			wait_q(1);
			if (i >= 2) `CHK(slots[base], e)
		end
		$display("test freeze codes done");
		wr(ASC_OFS_CTL, 32'h0000_0014);
		base = slots.size();
		wr(ASC_OFS_START, 32'h0000_0002);
		for (i = 0; i < 2; i++) begin
			repeat (20) @(posedge aclk);
			`CHK(slots.size() - base, 2 * i)
			ext_trigger <= 1'b1;
			@(posedge aclk);
			ext_trigger <= 1'b0;
			wait_q(2 * i + 2);
		end
		for (j = 0; j < 4; j++) `CHK(slots[base + j], j[3:0])
		$display("test triggered fifo done");
		report_and_stop();
	end
endmodule
`default_nettype wire
